//--- ncirq_params.svh
`ifndef NCIRQ_PARAMS_SVH
`define NCIRQ_PARAMS_SVH

// register indices and byte addresses, four bytes per index
`define NCIRQ_IDX_STATUS 6'h05
`define NCIRQ_IDX_MASK 6'h04
`define NCIRQ_IDX_CLEAR 6'h06
`define NCIRQ_IDX_CTRL 6'h07
`define NCIRQ_ADDR_STATUS 8'h14
`define NCIRQ_ADDR_MASK 8'h10
`define NCIRQ_ADDR_CLEAR 8'h18
`define NCIRQ_ADDR_CTRL 8'h1C

// field positions
`define NCIRQ_BIT_RSVD 15
`define NCIRQ_BIT_RETRY 14
`define NCIRQ_BIT_HBEAT 13
`define NCIRQ_BIT_TBLDONE 12
`define NCIRQ_BIT_DESCIRQ 11
`define NCIRQ_BIT_RXDONE 10
`define NCIRQ_BIT_TXDONE 9
`define NCIRQ_CTRL_LATCHED 0

// reset values and masks
`define NCIRQ_STATUS_RST 16'h0000
`define NCIRQ_MASK_RST 16'h0000
`define NCIRQ_CTRL_RST 1'b0
`define NCIRQ_LIVE_BITS 16'h7FFF

// heartbeat window
`define NCIRQ_CLK_PERIOD_PS 10000
`define NCIRQ_HB_WINDOW_PS 6400000
`define NCIRQ_HB_CYCLES (`NCIRQ_HB_WINDOW_PS / `NCIRQ_CLK_PERIOD_PS)

`endif

//--- ncirq_pkg.sv
package ncirq_pkg;

    typedef struct packed {
        logic retry_request_input;
        logic bus_master;
        logic tx_frame_end;
        logic heartbeat_pulse;
        logic addr_table_load_done;
        logic descriptor_flag_irq;
        logic rx_descriptor_sequence;
        logic tx_descriptor_result;
        logic list_end_flag;
        logic halt_transmission_cmd;
        logic length_mismatch;
        logic too_many_collisions;
        logic fifo_underrun;
        logic deferral_overlong;
    } ncirq_event_s;

    typedef enum logic [2:0] {
        NCIRQ_HB_IDLE = 3'b001,
        NCIRQ_HB_WAIT = 3'b010,
        NCIRQ_HB_MISS = 3'b100
    } ncirq_hb_e;

    typedef logic [15:0] ncirq_word_t;

endpackage

//--- ncirq_status.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// - irq is high whenever a status bit is set and its mask bit is one.
// - a one written to a status bit clears it and a zero has no effect.
// - hardware reset clears all status bits, software reset leaves them.
// - bit 14 sets on bus retry, only as master when latched, stalling dma.
// - in unlatched mode dma resumes without waiting for bit 14 to clear.
// - bit 13 sets if no heartbeat arrives within 6.4 us after transmit.
// - bit 12 sets when the address table load has finished.
// - bit 11 sets when a descriptor config field carries its irq flag.
// - bit 10 sets after a frame is stored and its sequence field written.
// - bit 9 sets after the tx result is written on list end, halt or abort.
// - a transmit is aborted on length mismatch, collisions, underrun or deferral.
// - while irq is active at least one status bit reads as one.
// - mask bits enable their status bits and are cleared by hardware reset.
//////////////////////////////////////////////////////////////////////////////
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "ncirq_params.svh"

module ncirq_status
    import ncirq_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic soft_reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire ncirq_event_s events,
    input wire logic [8:0] low_events,
    output logic dma_stall,
    output logic tx_abort,
    output logic irq
);

    //////////////////////////////////////////////////////////////////////////
    // bus slave

    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic addr_ok;
    ncirq_word_t status_reg;
    ncirq_word_t status_next;
    ncirq_word_t mask_reg;
    logic latched_retry_mode_reg;
    ncirq_word_t clr_vec;
    ncirq_word_t set_vec;
    logic [31:0] rdata_next;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (clk_en)
        begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        unique case (haddr[7:0])
            `NCIRQ_ADDR_STATUS: rdata_next = {16'h0000, status_reg};
            `NCIRQ_ADDR_MASK: rdata_next = {16'h0000, mask_reg};
            `NCIRQ_ADDR_CTRL: rdata_next = {31'h0000_0000, latched_retry_mode_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (clk_en && addr_ok && !hwrite)
            hrdata <= rdata_next;
    end

    //////////////////////////////////////////////////////////////////////////
    // mask and control registers

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_reg <= `NCIRQ_MASK_RST;
        else if (clk_en && wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_MASK)
            mask_reg <= hwdata[15:0] & `NCIRQ_LIVE_BITS;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            latched_retry_mode_reg <= `NCIRQ_CTRL_RST;
        else if (clk_en && wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_CTRL)
            latched_retry_mode_reg <= hwdata[`NCIRQ_CTRL_LATCHED];
    end

    //////////////////////////////////////////////////////////////////////////
    // heartbeat window

    localparam int HB_W = 10;
    localparam logic [HB_W-1:0] HB_LAST = HB_W'(`NCIRQ_HB_CYCLES - 1);
    ncirq_hb_e hb_state_reg;
    logic [HB_W-1:0] hb_cnt_reg;
    logic hb_miss;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hb_state_reg <= NCIRQ_HB_IDLE;
            hb_cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            unique case (hb_state_reg)
                NCIRQ_HB_IDLE:
                begin
                    hb_cnt_reg <= '0;
                    if (events.tx_frame_end)
                        hb_state_reg <= NCIRQ_HB_WAIT;
                end
                NCIRQ_HB_WAIT:
                begin
                    hb_cnt_reg <= hb_cnt_reg + 1'b1;
                    if (events.heartbeat_pulse)
                        hb_state_reg <= NCIRQ_HB_IDLE;
                    else if (hb_cnt_reg == HB_LAST)
                        hb_state_reg <= NCIRQ_HB_MISS;
                end
                NCIRQ_HB_MISS:
                    hb_state_reg <= NCIRQ_HB_IDLE;
                default:
                    hb_state_reg <= NCIRQ_HB_IDLE;
            endcase
        end
    end

    assign hb_miss = hb_state_reg == NCIRQ_HB_MISS;

    //////////////////////////////////////////////////////////////////////////
    // event flags

    assign tx_abort = events.length_mismatch | events.too_many_collisions
        | events.fifo_underrun | events.deferral_overlong;

    always_comb
    begin
        set_vec = 16'h0000;
        set_vec[8:0] = low_events;
        set_vec[`NCIRQ_BIT_RETRY] = events.retry_request_input
            && (!latched_retry_mode_reg || events.bus_master);
        set_vec[`NCIRQ_BIT_HBEAT] = hb_miss;
        set_vec[`NCIRQ_BIT_TBLDONE] = events.addr_table_load_done;
        set_vec[`NCIRQ_BIT_DESCIRQ] = events.descriptor_flag_irq;
        set_vec[`NCIRQ_BIT_RXDONE] = events.rx_descriptor_sequence;
        set_vec[`NCIRQ_BIT_TXDONE] = events.tx_descriptor_result
            && (events.list_end_flag || events.halt_transmission_cmd || tx_abort);
        clr_vec = 16'h0000;
        if (wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_CLEAR)
            clr_vec = hwdata[15:0];
        if (wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_STATUS)
            clr_vec = hwdata[15:0];
        status_next = ((status_reg & ~clr_vec) | set_vec) & `NCIRQ_LIVE_BITS;
    end

    // soft_reset deliberately not used on status
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_reg <= `NCIRQ_STATUS_RST;
        else if (clk_en)
            status_reg <= status_next;
    end

    assign dma_stall = latched_retry_mode_reg && status_reg[`NCIRQ_BIT_RETRY];
    assign irq = |(status_reg & mask_reg);

    //////////////////////////////////////////////////////////////////////////
    // checks

    property p_irq_src;
        @(posedge hclk) disable iff (!hresetn)
        irq |-> (status_reg != 16'h0000) && ((status_reg & mask_reg) != 16'h0000);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq without source");

    property p_irq_on;
        @(posedge hclk) disable iff (!hresetn)
        (|(status_reg & mask_reg)) |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");

    property p_w1c;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_STATUS && hwdata[9]
            && !set_vec[9] |=> !status_reg[9];
    endproperty
    a_w1c: assert property (p_w1c) else $error("w1c failed");

    property p_zero_keeps;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_STATUS
            |=> ($past(status_reg) & ~$past(hwdata[15:0]) & ~status_reg) == 16'h0000;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared");

    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && set_vec[11] && clr_vec[11] |=> status_reg[11];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        !status_reg[15] && !mask_reg[15];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

    property p_soft;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && soft_reset && status_reg[11] && !wr_pend_reg |=> status_reg[11];
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset touched status");

    property p_latched_master;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && latched_retry_mode_reg && !events.bus_master && !status_reg[14]
            |=> !status_reg[14];
    endproperty
    a_latched_master: assert property (p_latched_master) else $error("retry not master");

    property p_stall;
        @(posedge hclk) disable iff (!hresetn)
        status_reg[14] |-> dma_stall == latched_retry_mode_reg;
    endproperty
    a_stall: assert property (p_stall) else $error("stall mismatch");

    property p_hb;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && hb_state_reg == NCIRQ_HB_MISS |=> status_reg[13];
    endproperty
    a_hb: assert property (p_hb) else $error("heartbeat flag missing");

    property p_txdone;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && events.tx_descriptor_result && events.fifo_underrun |=> status_reg[9];
    endproperty
    a_txdone: assert property (p_txdone) else $error("tx done missing");

    property p_txdone_quiet;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && events.tx_descriptor_result && !events.list_end_flag
            && !events.halt_transmission_cmd && !tx_abort && !status_reg[9]
            |=> !status_reg[9];
    endproperty
    a_txdone_quiet: assert property (p_txdone_quiet) else $error("tx done spurious");

    property p_rd_status;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && addr_ok && !hwrite && haddr[7:0] == `NCIRQ_ADDR_STATUS
            |=> hrdata == {16'h0000, $past(status_reg)};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read wrong");

    property p_rd_clear;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && addr_ok && !hwrite && haddr[7:0] == `NCIRQ_ADDR_CLEAR
            |=> hrdata == 32'h0000_0000;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("clear alias read nonzero");

    property p_mask_wr;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && wr_pend_reg && wr_addr_reg == `NCIRQ_ADDR_MASK
            |=> mask_reg == ($past(hwdata[15:0]) & `NCIRQ_LIVE_BITS);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    property p_unlatched;
        @(posedge hclk) disable iff (!hresetn)
        !latched_retry_mode_reg |-> !dma_stall;
    endproperty
    a_unlatched: assert property (p_unlatched) else $error("stall when unlatched");

    property p_retry_set;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && events.retry_request_input && events.bus_master |=> status_reg[14];
    endproperty
    a_retry_set: assert property (p_retry_set) else $error("retry flag missing");

    property p_hb_count;
        @(posedge hclk) disable iff (!hresetn)
        hb_state_reg == NCIRQ_HB_MISS |-> hb_cnt_reg == HB_W'(`NCIRQ_HB_CYCLES);
    endproperty
    a_hb_count: assert property (p_hb_count) else $error("heartbeat window length");

    property p_hb_heard;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && hb_state_reg == NCIRQ_HB_WAIT && events.heartbeat_pulse
            |=> hb_state_reg == NCIRQ_HB_IDLE;
    endproperty
    a_hb_heard: assert property (p_hb_heard) else $error("heartbeat ignored");

    property p_rx;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && events.rx_descriptor_sequence |=> status_reg[10];
    endproperty
    a_rx: assert property (p_rx) else $error("rx flag missing");

    property p_desc;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && events.descriptor_flag_irq |=> status_reg[11];
    endproperty
    a_desc: assert property (p_desc) else $error("descriptor flag missing");

    property p_tbl;
        @(posedge hclk) disable iff (!hresetn)
        clk_en && events.addr_table_load_done |=> status_reg[12];
    endproperty
    a_tbl: assert property (p_tbl) else $error("table done flag missing");

    property p_freeze;
        @(posedge hclk) disable iff (!hresetn)
        !clk_en |=> $stable(status_reg) && $stable(mask_reg) && $stable(hb_state_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
    c_hb: cover property (@(posedge hclk) disable iff (!hresetn) hb_miss);
    c_stall: cover property (@(posedge hclk) disable iff (!hresetn) $fell(dma_stall));
    c_collide: cover property (@(posedge hclk) disable iff (!hresetn) set_vec[11] && clr_vec[11]);
    c_soft: cover property (@(posedge hclk) disable iff (!hresetn) soft_reset && |status_reg);

endmodule // ncirq_status

//--- ncirq_host.sv
`timescale 1ns/1ns
module ncirq_host
    import ncirq_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic rd_valid,
    output logic [31:0] rd_data
);
    initial
    begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        rd_valid = 1'b0;
        rd_data = 32'h0;
    end
    // single word transfer, waits on hready with no assumed latency
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_data <= hrdata;
        rd_valid <= ~w;
        @(posedge hclk);
        rd_valid <= 1'b0;
    endtask
endmodule // ncirq_host

//--- tb_top.sv
`timescale 1ns/1ns
`include "ncirq_params.svh"
module tb_top
    import ncirq_pkg::*;
();
    localparam logic [31:0] ST = `NCIRQ_ADDR_STATUS;
    localparam logic [31:0] MK = `NCIRQ_ADDR_MASK;
    localparam logic [31:0] CL = `NCIRQ_ADDR_CLEAR;
    localparam logic [31:0] CT = `NCIRQ_ADDR_CTRL;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic soft_reset = 1'b0;
    logic clk_en = 1'b1;
    ncirq_event_s ev = '0;
    logic [8:0] low_ev = 9'h0;
    logic hsel, hwrite, hreadyout, hresp, dma_stall, tx_abort, irq, rd_valid;
    logic [31:0] haddr, hwdata, hrdata, rd_data, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] exp_q[$];
    logic [13:0] ev_tab[11] = '{14'h2000, 14'h0200, 14'h0100, 14'h0080, 14'h0060, 14'h0050,
        14'h0048, 14'h0044, 14'h0042, 14'h0041, 14'h0040};
    logic [15:0] ex_tab[11] = '{16'h4000, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0200,
        16'h0200, 16'h0200, 16'h0200, 16'h0200, 16'h0000};
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int seed = 97;

    always #5 hclk = ~hclk;

    ncirq_status u_ncirq_status (.hclk, .hresetn, .clk_en, .soft_reset, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .events(ev), .low_events(low_ev), .dma_stall, .tx_abort, .irq);
    ncirq_host u_ncirq_host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .rd_valid, .rd_data);

    //////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pin(input logic v, input logic e);
        cmp({31'h0, v}, {31'h0, e});
    endtask
    task automatic test_done();
        $display("errors=%0d checks=%0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        u_ncirq_host.xfer(1'b1, a, v);
        pin(hresp, 1'b0);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_ncirq_host.xfer(1'b0, a, 32'h0);
    endtask
    // one-cycle event, abort output checked while it stands
    task automatic pulse(input logic [13:0] e, input logic [8:0] l);
        @(posedge hclk);
        ev <= ncirq_event_s'(e);
        low_ev <= l;
        #2 pin(tx_abort, |e[3:0]);
        @(posedge hclk);
        ev <= '0;
        low_ev <= 9'h0;
        #1;
    endtask

    //////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk)
        if (rd_valid === 1'b1)
            cmp(rd_data, exp_q.pop_front());

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            test_done();
        end
    end

    initial
    begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd(ST, 0);
        rd(MK, 0);
        rd(CT, 0);
        wr(32'h20, 32'hFFFF);
        rd(32'h20, 0);
        for (int i = 0; i < 11; i++)
        begin
            wr(ST, 32'hFFFF);
            pulse(ev_tab[i], 9'h0);
            rd(ST, {16'h0, ex_tab[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            wr(ST, 32'hFFFF);
            d = $random(seed);
            pulse(14'h0, d[8:0]);
            rd(ST, {23'h0, d[8:0]});
            wr(MK, d);
            rd(MK, d & 32'h7FFF);
        end
        wr(ST, 32'hFFFF);
        wr(MK, 0);
        pulse(14'h0100, 9'h0);
        pin(irq, 1'b0);
        wr(MK, 32'h0800);
        pin(irq, 1'b1);
        wr(ST, 32'h0);
        rd(ST, 32'h0800);
        wr(CL, 32'h0800);
        rd(ST, 0);
        rd(CL, 0);
        pin(irq, 1'b0);
        fork
            wr(ST, 32'h0800);
            begin
                repeat (2) @(posedge hclk);
                ev <= ncirq_event_s'(14'h0100);
                @(posedge hclk);
                ev <= '0;
            end
        join
        rd(ST, 32'h0800);
        pulse(14'h0800, 9'h0);
        repeat (600) @(posedge hclk);
        pulse(14'h0400, 9'h0);
        repeat (100) @(posedge hclk);
        rd(ST, 32'h0800);
        pulse(14'h0800, 9'h0);
        repeat (700) @(posedge hclk);
        rd(ST, 32'h2800);
        wr(ST, 32'hFFFF);
        wr(CT, 1);
        rd(CT, 1);
        pulse(14'h2000, 9'h0);
        rd(ST, 0);
        pulse(14'h3000, 9'h0);
        rd(ST, 32'h4000);
        pin(dma_stall, 1'b1);
        wr(ST, 32'h4000);
        pin(dma_stall, 1'b0);
        wr(CT, 0);
        pulse(14'h2000, 9'h0);
        pin(dma_stall, 1'b0);
        pulse(14'h0100, 9'h0);
        @(posedge hclk);
        soft_reset <= 1'b1;
        repeat (3) @(posedge hclk);
        soft_reset <= 1'b0;
        rd(ST, 32'h4800);
        pin(irq, 1'b1);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        #1 pin(irq, 1'b0);
        rd(ST, 0);
        rd(MK, 0);
        clk_en <= 1'b0;
        pulse(14'h0080, 9'h0);
        @(posedge hclk);
        clk_en <= 1'b1;
        rd(ST, 0);
        pulse(14'h0080, 9'h0);
        rd(ST, 32'h0400);
        repeat (3) @(posedge hclk);
        test_done();
    end
endmodule // tb_top
